// ==== logic/clock_divider_ctrl.sv ====
// clock divider, postscaler settings and module disable registers over apb
`timescale 1ns/100ps
`default_nettype none
`include "clock_divider_defines.svh"

module clock_divider_ctrl (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          por_n,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          interrupt_event,
  input  wire logic                          instr_tick,
  input  wire logic                          rc_osc_tick,
  output logic                               cpu_tick,
  output logic                               rc_div_tick,
  output logic      [5:0]                    pll_in_div_factor,
  output logic      [3:0]                    pll_out_div_factor,
  output clock_divider_pkg::pow2_code_t      clock_reduction_ratio,
  output logic                               comparator_disable,
  output logic                               refclk_gen_disable,
  output logic                               comparator_two_disable,
  output logic                               comparator_one_disable
);
  import clock_divider_pkg::*;

  reg_word_t clkdiv;
  reg_word_t module_disable_three;
  reg_word_t module_disable_four;
  reg_word_t module_disable_seven;
  logic      irq_meta;
  logic      irq_sync;
  logic      write_access;
  logic      read_access;
  logic      known_addr;
  reg_word_t next_clkdiv;

  function automatic logic [8:0] pow2_div(input pow2_code_t code);
    pow2_div = 9'd1 << code;
  endfunction : pow2_div

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == `CLKDIV_OFFSET) || (a == `MODULE_DISABLE_THREE_OFFSET) ||
               (a == `MODULE_DISABLE_FOUR_OFFSET) || (a == `MODULE_DISABLE_SEVEN_OFFSET);
  endfunction : addr_hit

  assign write_access = psel && penable && pwrite;
  assign read_access  = psel && !penable && !pwrite;
  assign known_addr   = addr_hit(paddr);
  assign pready       = 1'b1;
  assign pslverr      = psel && penable && !known_addr;

  // interrupt comes from another part of the chip; synchronise it first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_meta <= 1'b0;
      irq_sync <= 1'b0;
    end else begin
      irq_meta <= interrupt_event;
      irq_sync <= irq_meta;
    end
  end

  always_comb begin
    next_clkdiv = clkdiv;
    if (write_access && paddr == `CLKDIV_OFFSET) begin
      next_clkdiv = pwdata[15:0] & `CLKDIV_WRITE_MASK;
    end
    // hardware clear wins over a same-cycle software set
    if (next_clkdiv[`ROI_BIT] && irq_sync) begin
      next_clkdiv[`CLOCK_REDUCTION_ENABLE_BIT] = 1'b0;
    end
  end

  // held through warm resets, loaded with 16'h3040 only by power-on
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      clkdiv <= `CLKDIV_RESET;
    end else begin
      clkdiv <= next_clkdiv;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_disable_three <= `PMD_RESET;
      module_disable_four <= `PMD_RESET;
      module_disable_seven <= `PMD_RESET;
    end else if (write_access) begin
      if (paddr == `MODULE_DISABLE_THREE_OFFSET) begin
        module_disable_three <= pwdata[15:0] & `MODULE_DISABLE_THREE_WRITE_MASK;
      end
      if (paddr == `MODULE_DISABLE_FOUR_OFFSET) begin
        module_disable_four <= pwdata[15:0] & `MODULE_DISABLE_FOUR_WRITE_MASK;
      end
      if (paddr == `MODULE_DISABLE_SEVEN_OFFSET) begin
        module_disable_seven <= pwdata[15:0] & `MODULE_DISABLE_SEVEN_WRITE_MASK;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (read_access) begin
      unique case (paddr)
        `CLKDIV_OFFSET: prdata <= {16'h0000, clkdiv};
        `MODULE_DISABLE_THREE_OFFSET:   prdata <= {16'h0000, module_disable_three};
        `MODULE_DISABLE_FOUR_OFFSET:   prdata <= {16'h0000, module_disable_four};
        `MODULE_DISABLE_SEVEN_OFFSET:   prdata <= {16'h0000, module_disable_seven};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

  // code 111 is reserved; treat it as the largest ratio
  always_comb begin
    clock_reduction_ratio = 3'd0;
    if (clkdiv[`CLOCK_REDUCTION_ENABLE_BIT]) begin
      clock_reduction_ratio = clkdiv[`DOZE_MSB:`DOZE_LSB];
    end
    if (clock_reduction_ratio == 3'd7) begin
      clock_reduction_ratio = 3'd6;
    end
  end

  pulse_divider cpu_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .src_tick (instr_tick),
    .divisor  (pow2_div(clock_reduction_ratio)),
    .out_tick (cpu_tick)
  );

  logic [8:0] rc_divisor;

  always_comb begin
    rc_divisor = pow2_div(clkdiv[`FRCDIV_MSB:`FRCDIV_LSB]);
    if (clkdiv[`FRCDIV_MSB:`FRCDIV_LSB] == 3'd7) begin
      rc_divisor = 9'd256;
    end
  end

  pulse_divider rc_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .src_tick (rc_osc_tick),
    .divisor  (rc_divisor),
    .out_tick (rc_div_tick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_in_div_factor <= 6'd2;
    end else begin
      pll_in_div_factor <= {1'b0, clkdiv[`PLLPRE_MSB:`PLLPRE_LSB]} + 6'd2;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_out_div_factor <= 4'd4;
    end else begin
      unique case (clkdiv[`PLLPOST_MSB:`PLLPOST_LSB])
        2'b00:   pll_out_div_factor <= 4'd2;
        2'b01:   pll_out_div_factor <= 4'd4;
        default: pll_out_div_factor <= 4'd8;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comparator_disable     <= 1'b0;
      refclk_gen_disable     <= 1'b0;
      comparator_two_disable <= 1'b0;
      comparator_one_disable <= 1'b0;
    end else begin
      comparator_disable     <= module_disable_three[`CMP_DISABLE_BIT];
      refclk_gen_disable     <= module_disable_four[`REFCLK_DISABLE_BIT];
      comparator_two_disable <= module_disable_seven[`CMP2_DISABLE_BIT];
      comparator_one_disable <= module_disable_seven[`CMP1_DISABLE_BIT];
    end
  end

endmodule : clock_divider_ctrl
`default_nettype wire

// ==== logic/clock_divider_defines.svh ====
// offsets, field positions, reset values and counts of the clock divider block
`ifndef CLOCK_DIVIDER_DEFINES_SVH
`define CLOCK_DIVIDER_DEFINES_SVH

`define CLKDIV_OFFSET          12'h000
`define MODULE_DISABLE_THREE_OFFSET            12'h004
`define MODULE_DISABLE_FOUR_OFFSET            12'h008
`define MODULE_DISABLE_SEVEN_OFFSET            12'h00C

`define CLKDIV_RESET           16'h3040
`define CLKDIV_WRITE_MASK      16'hFFDF
`define MODULE_DISABLE_THREE_WRITE_MASK        16'h0400
`define MODULE_DISABLE_FOUR_WRITE_MASK        16'h0008
`define MODULE_DISABLE_SEVEN_WRITE_MASK        16'h0300
`define PMD_RESET              16'h0000

`define ROI_BIT                15
`define DOZE_MSB               14
`define DOZE_LSB               12
`define CLOCK_REDUCTION_ENABLE_BIT              11
`define FRCDIV_MSB             10
`define FRCDIV_LSB             8
`define PLLPOST_MSB            7
`define PLLPOST_LSB            6
`define PLLPRE_MSB             4
`define PLLPRE_LSB             0

`define CMP_DISABLE_BIT        10
`define REFCLK_DISABLE_BIT     3
`define CMP2_DISABLE_BIT       9
`define CMP1_DISABLE_BIT       8

`define DIV_COUNT_WIDTH        8

`endif

// ==== logic/clock_divider_pkg.sv ====
// types shared by the clock divider block
package clock_divider_pkg;

  typedef logic [15:0] reg_word_t;
  typedef logic [2:0]  pow2_code_t;
  typedef logic [1:0]  post_code_t;
  typedef logic [4:0]  pre_code_t;

endpackage : clock_divider_pkg

// ==== logic/pulse_divider.sv ====
// divide-by-n clock enable generator, n given as a count
`timescale 1ns/100ps
`default_nettype none
`include "clock_divider_defines.svh"

module pulse_divider (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        src_tick,
  input  wire logic [`DIV_COUNT_WIDTH:0]   divisor,
  output logic                             out_tick
);

  logic [`DIV_COUNT_WIDTH:0] count;

  // divisor of one passes every source tick straight through
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (src_tick) begin
      if (count + 9'd1 >= divisor) begin
        count <= '0;
      end else begin
        count <= count + 9'd1;
      end
    end
  end

  assign out_tick = src_tick && (count + 9'd1 >= divisor);

endmodule : pulse_divider
`default_nettype wire

// ==== verification/clock_divider_sva.sv ====
// assertion checker for the clock divider block
`timescale 1ns/100ps
`default_nettype none
`include "clock_divider_defines.svh"
module clock_divider_sva (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [11:0]                  paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic [31:0]                  prdata,
  input wire logic                         pslverr,
  input wire logic                         instr_tick,
  input wire logic                         cpu_tick,
  input wire logic [5:0]                   pll_in_div_factor,
  input wire logic [3:0]                   pll_out_div_factor,
  input wire clock_divider_pkg::pow2_code_t clock_reduction_ratio,
  input wire logic                         comparator_disable
);
  import clock_divider_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  // only the space above the last register counts as unmapped here
  wire unm = paddr > 12'h00C;
  property p_ratio_one; clock_reduction_ratio == 3'h0 |-> cpu_tick == instr_tick; endproperty
  a_ratio_one: assert property (p_ratio_one) else $error("cpu tick differs at ratio zero");
  property p_tick_src; cpu_tick |-> instr_tick; endproperty
  a_tick_src: assert property (p_tick_src) else $error("cpu tick without instr tick");
  property p_ratio_max; clock_reduction_ratio != 3'h7; endproperty
  a_ratio_max: assert property (p_ratio_max) else $error("ratio above six");
  property p_pre_range; pll_in_div_factor inside {[6'h02:6'h21]}; endproperty
  a_pre_range: assert property (p_pre_range) else $error("input divider out of range");
  property p_post_set; pll_out_div_factor inside {4'h2, 4'h4, 4'h8}; endproperty
  a_post_set: assert property (p_post_set) else $error("output divider not 2, 4 or 8");
  property p_unm_err; acc && unm |-> pslverr; endproperty
  a_unm_err: assert property (p_unm_err) else $error("no error on unmapped access");
  property p_unm_zero; acc && !pwrite && unm |-> prdata == 32'h0000_0000; endproperty
  a_unm_zero: assert property (p_unm_zero) else $error("unmapped read not zero");
  property p_cmp; acc && pwrite && paddr == `MODULE_DISABLE_THREE_OFFSET |=> ##1 comparator_disable == $past(pwdata[10], 2); endproperty
  a_cmp: assert property (p_cmp) else $error("comparator disable does not follow write");
  c_unm: cover property (acc && unm);
  c_doze: cover property (cpu_tick && clock_reduction_ratio == 3'h6);
  c_cmp: cover property (comparator_disable);
endmodule : clock_divider_sva
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking testbench of the clock divider block
`timescale 1ns/100ps
`default_nettype none
bind clock_divider_ctrl clock_divider_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .instr_tick(instr_tick),
  .cpu_tick(cpu_tick), .pll_in_div_factor(pll_in_div_factor), .pll_out_div_factor(pll_out_div_factor),
  .clock_reduction_ratio(clock_reduction_ratio), .comparator_disable(comparator_disable));
module tb_top;
  import clock_divider_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic        pclk = 1'b0, presetn = 1'b0, por_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        irq = 1'b0, pready, pslverr, cpu_tick, rc_div_tick, cd, rd, c2d, c1d;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic [5:0]  pin;
  logic [3:0]  pout;
  pow2_code_t  ratio;
  int          error_cnt = 0, n_checks = 0, c;
  row_t        rows[6] = '{'{12'h000, 32'hFFFF_FFFF, 32'h0000_FFDF}, '{12'h004, 32'hFFFF_FFFF, 32'h0000_0400},
    '{12'h008, 32'hFFFF_FFFF, 32'h0000_0008}, '{12'h00C, 32'hFFFF_FFFF, 32'h0000_0300},
    '{12'h010, 32'hFFFF_FFFF, 32'h0000_0000}, '{12'h000, 32'h0000_0000, 32'h0000_0000}};
  always #2.5 pclk = ~pclk;
  clock_divider_ctrl dut_u (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .interrupt_event(irq), .instr_tick(1'b1), .rc_osc_tick(1'b1), .cpu_tick(cpu_tick), .rc_div_tick(rc_div_tick),
    .pll_in_div_factor(pin), .pll_out_div_factor(pout), .clock_reduction_ratio(ratio), .comparator_disable(cd),
    .refclk_gen_disable(rd), .comparator_two_disable(c2d), .comparator_one_disable(c1d));
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // counts output pulses while the source ticks every cycle
  task automatic cnt(input bit rc, input int n);
    c = 0;
    repeat (n) begin
      @(posedge pclk);
      c += (rc ? rc_div_tick : cpu_tick) === 1'b1;
    end
  endtask : cnt
  task automatic rst(input logic p);
    @(posedge pclk);
    presetn <= 1'b0;
    por_n   <= p;
    @(posedge pclk);
    presetn <= 1'b1;
    por_n   <= 1'b1;
  endtask : rst
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    por_n   <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0000_0000);
      chk(q, rows[i].e);
    end
    chk({cd, rd, c2d, c1d}, 4'hF);
    $display("test register rows done");
    bus(1'b1, 12'h000, 32'h0000_3FDF);
    // divider factors are registered one edge after the register itself
    repeat (2) @(posedge pclk);
    chk({pin, pout}, 10'h218);
    cnt(1'b1, 512);
    chk(c, 2);
    cnt(1'b0, 64);
    chk(c, 8);
    rst(1'b1);
    bus(1'b0, 12'h000, 32'h0000_0000);
    chk(q, 32'h0000_3FDF);
    bus(1'b0, 12'h00C, 32'h0000_0000);
    chk({q[9:0], c2d, c1d}, 12'h000);
    $display("test divider and system reset done");
    bus(1'b1, 12'h000, 32'h0000_E840);
    cnt(1'b0, 256);
    chk(c, 4);
    irq <= 1'b1;
    repeat (2) @(posedge pclk);
    irq <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(ratio, 3'h0);
    bus(1'b0, 12'h000, 32'h0000_0000);
    chk(q, 32'h0000_E040);
    cnt(1'b0, 16);
    chk(c, 16);
    $display("test interrupt recovery done");
    rst(1'b0);
    bus(1'b0, 12'h000, 32'h0000_0000);
    chk(q, 32'h0000_3040);
    chk({pin, pout}, 10'h024);
    $display("test power-on reset done");
    give_verdict();
  end
  // whole run is about 920 cycles
  initial begin
    #50000;
    error_cnt++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
